// ---- logic/wdt_pkg.sv ----
// package with the watchdog register map, fields, reset values and states
package wdt_pkg;
  // register byte addresses (offsets from the block base, 32-bit words)
  localparam logic [11:0] UNLOCK_STATUS_ADDR = 12'h000;
  localparam logic [11:0] RELOAD_UPPER_ADDR  = 12'h004;
  localparam logic [11:0] RELOAD_MIDDLE_ADDR = 12'h008;
  localparam logic [11:0] RELOAD_LOW_ADDR    = 12'h00c;
  localparam logic [11:0] CONTROL_ADDR       = 12'h010;
  localparam logic [11:0] STATUS_ADDR        = 12'h014;
  // reset values of the reload bytes
  localparam logic [7:0]  RELOAD_UPPER_RST   = 8'h00;
  localparam logic [7:0]  RELOAD_MIDDLE_RST  = 8'h04;
  localparam logic [7:0]  RELOAD_LOW_RST     = 8'h00;
  // unlock key bytes
  localparam logic [7:0]  UNLOCK_KEY_FIRST   = 8'h55;
  localparam logic [7:0]  UNLOCK_KEY_SECOND  = 8'haa;
  // counter thresholds
  localparam logic [23:0] REFRESH_LIMIT      = 24'h000002;
  localparam logic [23:0] COUNT_MAX          = 24'hffffff;
  localparam logic [23:0] COUNT_ZERO         = 24'h000000;
  // reset status fields
  localparam int          STAT_WDT_BIT       = 5;
  localparam int          STAT_STOP_BIT      = 4;
  // control register fields
  localparam int          CTRL_STOP_BIT      = 0;
  // watchdog tick rate and system clock rate
  localparam int          WDT_OSC_HZ         = 10000;
  localparam int          SYS_CLK_HZ         = 20000000;
  localparam int          TICK_DIV_CYCLES    = SYS_CLK_HZ / WDT_OSC_HZ;

  // unlock and reload sequence states
  typedef enum logic [2:0] {
    LOCKED     = 3'b000,
    GOT_FIRST  = 3'b001,
    WANT_UPPER = 3'b010,
    WANT_MID   = 3'b011,
    WANT_LOW   = 3'b100
  } lock_state_t;
endpackage

// ---- logic/wdt_tick_gen.sv ----
// tick generator standing in for the watchdog oscillator
`timescale 1ns/10ps
module wdt_tick_gen #(
  parameter int DIV = wdt_pkg::TICK_DIV_CYCLES
) (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic clkEn,
  output logic      tick
);
  // ==========================================================
  // divider
  initial begin
    if (DIV < 2 || DIV > 65536) begin
      $error("wdt_tick_gen: DIV must lie between 2 and 65536");
    end
  end

  logic [15:0] cnt_q;
  wire         wrap = (cnt_q == 16'(DIV - 1));

  // one-cycle tick each DIV cycles; a single domain keeps refresh lossless
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= 16'h0000;
      tick  <= 1'b0;
    end else if (clkEn) begin
      cnt_q <= wrap ? 16'h0000 : cnt_q + 16'h0001;
      tick  <= wrap;
    end
  end
endmodule

// ---- logic/reloadable_watchdog_timer.sv ----
// reloadable 24-bit watchdog with locked reload registers over APB
//
// Our own choices: the APB slave port and the placing of the registers.
`timescale 1ns/10ps
module reloadable_watchdog_timer #(
  parameter int TICK_DIV = wdt_pkg::TICK_DIV_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        clkEn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        watchdogRefreshInstruction,
  input  wire logic        alwaysOnOption,
  input  wire logic        timeoutResponseOption,
  input  wire logic        stopMode,
  output logic             wdtIrq,
  output logic             sysResetReq,
  output logic             stopRecovery,
  output logic             wdtEnabled
);
  // ==========================================================
  // elaboration checks
  initial begin
    if (TICK_DIV < 2) begin
      $error("reloadable_watchdog_timer: TICK_DIV must be at least 2");
    end
  end

  // ==========================================================
  // bus decode
  function automatic logic isAddr(input logic [11:0] a,
                                  input logic [11:0] ref_a);
    return a == ref_a;
  endfunction

  wire       access   = psel && penable;
  wire       wrStrobe = access && pwrite;
  wire       rdStrobe = access && !pwrite;
  wire       hitUnlk  = isAddr(paddr, wdt_pkg::UNLOCK_STATUS_ADDR);
  wire       hitUpper = isAddr(paddr, wdt_pkg::RELOAD_UPPER_ADDR);
  wire       hitMid   = isAddr(paddr, wdt_pkg::RELOAD_MIDDLE_ADDR);
  wire       hitLow   = isAddr(paddr, wdt_pkg::RELOAD_LOW_ADDR);
  wire       hitCtrl  = isAddr(paddr, wdt_pkg::CONTROL_ADDR);
  wire       hitStat  = isAddr(paddr, wdt_pkg::STATUS_ADDR);
  wire       mapped   = hitUnlk | hitUpper | hitMid | hitLow
                        | hitCtrl | hitStat;
  wire [7:0] wrByte   = pwdata[7:0];

  // ==========================================================
  // state
  wdt_pkg::lock_state_t lock_q;
  wdt_pkg::lock_state_t lock_d;
  logic [7:0]  upper_q;
  logic [7:0]  mid_q;
  logic [7:0]  low_q;
  logic [23:0] count_q;
  logic        on_q;
  logic        flagWdt_q;
  logic        flagStop_q;
  logic        irqArm_q;
  logic        ctrlStop_q;
  logic        refreshPrev_q;
  logic        refreshPend_q;
  logic        tick;

  wire [23:0] reloadVal = {upper_q, mid_q, low_q};
  wire        stopNow   = stopMode | ctrlStop_q;

  // ==========================================================
  // tick source
  wdt_tick_gen #(
    .DIV (TICK_DIV)
  ) u_tick (
    .clk   (clk),
    .rst_b (rst_b),
    .clkEn (clkEn),
    .tick  (tick)
  );

  // ==========================================================
  // lock sequence
  always_comb begin
    lock_d = lock_q;
    if (wrStrobe) begin
      case (lock_q)
        wdt_pkg::LOCKED: begin
          lock_d = (hitUnlk && wrByte == wdt_pkg::UNLOCK_KEY_FIRST)
                   ? wdt_pkg::GOT_FIRST : wdt_pkg::LOCKED;
        end
        wdt_pkg::GOT_FIRST: begin
          lock_d = (hitUnlk && wrByte == wdt_pkg::UNLOCK_KEY_SECOND)
                   ? wdt_pkg::WANT_UPPER : wdt_pkg::LOCKED;
        end
        wdt_pkg::WANT_UPPER: begin
          lock_d = hitUpper ? wdt_pkg::WANT_MID : wdt_pkg::LOCKED;
        end
        wdt_pkg::WANT_MID: begin
          lock_d = hitMid ? wdt_pkg::WANT_LOW : wdt_pkg::LOCKED;
        end
        wdt_pkg::WANT_LOW: begin
          lock_d = wdt_pkg::LOCKED;
        end
        default: begin
          lock_d = wdt_pkg::LOCKED;
        end
      endcase
    end
  end

  wire wrUpper = wrStrobe && hitUpper && lock_q == wdt_pkg::WANT_UPPER;
  wire wrMid   = wrStrobe && hitMid && lock_q == wdt_pkg::WANT_MID;
  wire wrLow   = wrStrobe && hitLow && lock_q == wdt_pkg::WANT_LOW;

  // lock state and the reload bytes it guards
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lock_q  <= wdt_pkg::LOCKED;
      upper_q <= wdt_pkg::RELOAD_UPPER_RST;
      mid_q   <= wdt_pkg::RELOAD_MIDDLE_RST;
      low_q   <= wdt_pkg::RELOAD_LOW_RST;
    end else if (clkEn) begin
      lock_q <= lock_d;
      if (wrUpper) begin
        upper_q <= wrByte;
      end
      if (wrMid) begin
        mid_q <= wrByte;
      end
      if (wrLow) begin
        low_q <= wrByte;
      end
    end
  end

  // ==========================================================
  // refresh capture
  // the refresh pulse is held pending until the next tick, so a
  // pulse between ticks is neither lost nor counted twice
  wire refreshEdge = watchdogRefreshInstruction && !refreshPrev_q;
  wire refreshOk   = count_q > wdt_pkg::REFRESH_LIMIT;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      refreshPrev_q <= 1'b0;
      refreshPend_q <= 1'b0;
    end else if (clkEn) begin
      refreshPrev_q <= watchdogRefreshInstruction;
      if (refreshEdge && on_q) begin
        refreshPend_q <= 1'b1;
      end else if (tick) begin
        refreshPend_q <= 1'b0;
      end
    end
  end

  // ==========================================================
  // counter
  // always-on is taken a cycle after release, never in the reset term
  wire startNow = !on_q && (refreshEdge || alwaysOnOption);
  wire atZero   = count_q == wdt_pkg::COUNT_ZERO;
  // a refresh pending at count zero is too late and cannot hold it off
  wire timeout  = on_q && tick && atZero;
  wire intMode  = !timeoutResponseOption;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      on_q    <= 1'b0;
      count_q <= wdt_pkg::COUNT_ZERO;
    end else if (clkEn) begin
      if (startNow) begin
        on_q    <= 1'b1;
        count_q <= reloadVal;
      end else if (on_q && tick) begin
        if (refreshPend_q && refreshOk) begin
          count_q <= reloadVal;
        end else if (atZero) begin
          count_q <= wdt_pkg::COUNT_MAX;
        end else begin
          count_q <= count_q - 24'h000001;
        end
      end
    end
  end

  // ==========================================================
  // timeout response
  wire statRead = rdStrobe && (hitUnlk || hitStat);
  wire irqFire  = timeout && intMode && irqArm_q;

  // flags set by a timeout win over the clearing read in the same cycle
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      flagWdt_q  <= 1'b0;
      flagStop_q <= 1'b0;
      irqArm_q   <= 1'b1;
      wdtIrq     <= 1'b0;
      sysResetReq  <= 1'b0;
      stopRecovery <= 1'b0;
    end else if (clkEn) begin
      wdtIrq       <= irqFire;
      sysResetReq  <= timeout && !intMode && !stopNow;
      stopRecovery <= timeout && stopNow;
      if (timeout) begin
        flagWdt_q <= 1'b1;
        if (stopNow) begin
          flagStop_q <= 1'b1;
        end
      end else if (statRead) begin
        flagWdt_q  <= 1'b0;
        flagStop_q <= 1'b0;
      end
      if (irqFire) begin
        irqArm_q <= 1'b0;
      end else if (statRead) begin
        irqArm_q <= 1'b1;
      end
    end
  end

  // ==========================================================
  // control register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrlStop_q <= 1'b0;
    end else if (clkEn) begin
      if (wrStrobe && hitCtrl) begin
        ctrlStop_q <= pwdata[wdt_pkg::CTRL_STOP_BIT];
      end
    end
  end

  // ==========================================================
  // read mux
  logic [7:0] statusByte;
  always_comb begin
    statusByte = 8'h00;
    statusByte[wdt_pkg::STAT_WDT_BIT]  = flagWdt_q;
    statusByte[wdt_pkg::STAT_STOP_BIT] = flagStop_q;
  end

  wire [7:0] rdByte =
      (hitUnlk || hitStat) ? statusByte :
      hitUpper ? count_q[23:16] :
      hitMid   ? count_q[15:8]  :
      hitLow   ? count_q[7:0]   :
      hitCtrl  ? {7'h00, ctrlStop_q} : 8'h00;

  // zero-wait slave: answer registered in the setup cycle for the access cycle
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prdata     <= 32'h00000000;
      pready     <= 1'b0;
      pslverr    <= 1'b0;
      wdtEnabled <= 1'b0;
    end else if (clkEn) begin
      wdtEnabled <= on_q || startNow;
      pready     <= psel && !penable;
      pslverr    <= psel && !penable && !mapped;
      if (psel && !penable && !pwrite) begin
        prdata <= {24'h000000, rdByte};
      end
    end
  end
endmodule

// ---- sim/wdt_cpu_model.sv ----
// core-side model issuing watchdog refresh instructions
`timescale 1ns/10ps
module wdt_cpu_model (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic doRefresh,
  output logic      watchdogRefreshInstruction
);
  logic [1:0] holdCnt_q;
  // ==========================================
  // refresh request
  // held two cycles so the block sees one clean rising edge
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      holdCnt_q <= 2'h0;
    end else if (doRefresh) begin
      holdCnt_q <= 2'h2;
    end else if (holdCnt_q != 2'h0) begin
      holdCnt_q <= holdCnt_q - 2'h1;
    end
  end
  assign watchdogRefreshInstruction = (holdCnt_q != 2'h0);
endmodule

// ---- sim/wdt_assertions.sv ----
// port-level checker for the reloadable watchdog
`timescale 1ns/10ps
module wdt_checker (
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [11:0] paddr,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        alwaysOnOption,
  input wire logic        timeoutResponseOption,
  input wire logic        stopMode,
  input wire logic        wdtIrq,
  input wire logic        sysResetReq,
  input wire logic        stopRecovery,
  input wire logic        wdtEnabled
);
  // ==========================================
  // bus answers and time-out responses
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_ready_follows: assert property (psel && !penable |=> pready)
    else $error("pready missing");
  a_unmapped_err: assert property (psel && !penable && paddr > 12'h014
    |=> pready && pslverr) else $error("no slave error");
  a_irq_mode: assert property (wdtIrq |-> !$past(timeoutResponseOption))
    else $error("irq in reset mode");
  a_reset_mode: assert property (sysResetReq |->
    $past(timeoutResponseOption) && !$past(stopMode))
    else $error("bad system reset");
  a_stop_recov: assert property (stopRecovery |-> $past(stopMode))
    else $error("recovery outside stop");
  a_stop_irq: assert property (wdtIrq && $past(stopMode) |-> stopRecovery)
    else $error("stop irq without recovery");
  a_enabled_holds: assert property (wdtEnabled |=> wdtEnabled)
    else $error("watchdog stopped");
  a_always_on: assert property (alwaysOnOption |=> wdtEnabled)
    else $error("always-on not enabled");
  a_irq_single: assert property (wdtIrq |=> !wdtIrq [*8])
    else $error("repeated irq");
  a_irq_needs_on: assert property (wdtIrq |-> wdtEnabled)
    else $error("irq while off");
  c_irq: cover property (wdtIrq);
  c_reset: cover property (sysResetReq);
  c_stop: cover property (stopRecovery && wdtIrq);
endmodule
bind reloadable_watchdog_timer wdt_checker uChk (.clk, .rst_b, .psel,
  .penable, .paddr, .pready, .pslverr, .alwaysOnOption,
  .timeoutResponseOption, .stopMode, .wdtIrq, .sysResetReq,
  .stopRecovery, .wdtEnabled);

// ---- sim/reloadable_watchdog_timer_tb.sv ----
// self-checking bench for the reloadable watchdog
`timescale 1ns/10ps
module reloadable_watchdog_timer_tb;
  logic        clk, rst_b, psel, penable, pwrite, doRefresh, errBit;
  logic        alwaysOnOption, timeoutResponseOption, stopMode;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, wdtIrq, sysResetReq, stopRecovery;
  logic        wdtEnabled, refreshIn;
  integer      n_errors, n_tests, seed, cyc, rel, m;
  // ==========================================
  // clock and design
  always #25 clk = ~clk;
  wdt_cpu_model cpu (.clk, .rst_b, .doRefresh,
    .watchdogRefreshInstruction(refreshIn));
  reloadable_watchdog_timer #(.TICK_DIV(4)) dut (.clk, .rst_b,
    .clkEn(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .watchdogRefreshInstruction(refreshIn),
    .alwaysOnOption, .timeoutResponseOption, .stopMode, .wdtIrq,
    .sysResetReq, .stopRecovery, .wdtEnabled);
  // ==========================================
  // checks and bus tasks
  task automatic close_out();
    $display("errors %0d tests %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic chk_win(input integer got, input integer lo, hi);
    n_tests++;
    if (got < lo || got > hi) begin
      n_errors++;
      $display("[FAIL] %0t delay %0d not %0d..%0d", $time, got, lo, hi);
    end
  endtask
  // holds the request until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    integer i;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (i = 0; i < 16 && pready !== 1'b1; i++) @(posedge clk);
    if (pready !== 1'b1) begin
      n_errors++;
      close_out();
    end
    rd = prdata;
    errBit = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic pulse();
    @(posedge clk);
    doRefresh <= 1'b1;
    @(posedge clk);
    doRefresh <= 1'b0;
  endtask
  task automatic do_reset();
    rst_b <= 1'b0;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
  endtask
  // bounded wait for any time-out response
  task automatic wait_evt(output integer n);
    for (n = 0; n < 3000 && (wdtIrq | sysResetReq | stopRecovery) !== 1'b1;
         n++) @(posedge clk);
    if (n == 3000) begin
      n_errors++;
      close_out();
    end
  endtask
  // ==========================================
  // scenarios
  initial begin
    {clk, rst_b, psel, penable, pwrite, doRefresh} = 6'h00;
    {alwaysOnOption, timeoutResponseOption, stopMode} = 3'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    {n_errors, n_tests} = 0;
    seed = 32'hab4f9348;
    // every response mode: irq, reset, stop irq, stop reset
    for (m = 0; m < 4; m++) begin
      timeoutResponseOption <= m[0];
      stopMode <= m[1];
      do_reset();
      apb(1'b0, wdt_pkg::RELOAD_LOW_ADDR, 32'h0);
      chk(rd, 32'h0);
      rel = 8 + ($random(seed) & 31);
      apb(1'b1, wdt_pkg::UNLOCK_STATUS_ADDR, 32'h55);
      apb(1'b1, wdt_pkg::UNLOCK_STATUS_ADDR, 32'haa);
      apb(1'b1, wdt_pkg::RELOAD_UPPER_ADDR, 32'h0);
      apb(1'b1, wdt_pkg::RELOAD_MIDDLE_ADDR, 32'h0);
      apb(1'b1, wdt_pkg::RELOAD_LOW_ADDR, rel);
      pulse();
      if (m == 0) begin
        repeat (rel * 2) @(posedge clk);
        pulse();
      end
      wait_evt(cyc);
      chk_win(cyc, rel * 4, rel * 4 + 14);
      chk({wdtIrq, sysResetReq, stopRecovery},
          {~m[0], m[0] & ~m[1], m[1]});
      apb(1'b0, m[0] ? wdt_pkg::STATUS_ADDR : 12'h000, 32'h0);
      chk(rd, 32'h20 | (m[1] << 4));
      apb(1'b0, wdt_pkg::UNLOCK_STATUS_ADDR, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, wdt_pkg::RELOAD_UPPER_ADDR, 32'h0);
      chk(rd, 32'hff);
      chk({31'h0, wdtEnabled}, 32'h1);
      $display("mode %0d done", m);
    end
    // a stray write relocks, so the reset reload value stays
    timeoutResponseOption <= 1'b0;
    stopMode <= 1'b0;
    do_reset();
    apb(1'b1, 12'h018, 32'h0);
    chk({31'h0, errBit}, 32'h1);
    apb(1'b1, wdt_pkg::UNLOCK_STATUS_ADDR, 32'h55);
    chk({31'h0, errBit}, 32'h0);
    apb(1'b1, wdt_pkg::UNLOCK_STATUS_ADDR, 32'haa);
    apb(1'b1, wdt_pkg::RELOAD_UPPER_ADDR, 32'h0);
    apb(1'b1, wdt_pkg::CONTROL_ADDR, 32'h0);
    apb(1'b1, wdt_pkg::RELOAD_MIDDLE_ADDR, 32'h0);
    apb(1'b1, wdt_pkg::RELOAD_LOW_ADDR, 32'h5);
    pulse();
    repeat (8) @(posedge clk);
    apb(1'b0, wdt_pkg::RELOAD_MIDDLE_ADDR, 32'h0);
    chk(rd, 32'h03);
    $display("relock done");
    // always-on option enables without a refresh
    alwaysOnOption <= 1'b1;
    do_reset();
    repeat (2) @(posedge clk);
    chk({31'h0, wdtEnabled}, 32'h1);
    $display("always-on done");
    close_out();
  end
endmodule
